//--- hdl/audio_event_pkg.sv
package audio_event_pkg;
	// register addresses on the control serial port register map
	localparam logic [6:0] RX_FAULT_FLAGS_ADDR = 7'h18;
	localparam logic [6:0] RX_FAULT_ENABLES_ADDR = 7'h19;
	localparam logic [6:0] CONVERTER_FAULT_FLAGS_ADDR = 7'h1a;
	localparam logic [6:0] CONVERTER_FAULT_ENABLES_ADDR = 7'h1b;
	localparam logic [6:0] EVENT_SUMMARY_ADDR = 7'h1c;
	localparam logic [6:0] EVENT_SUMMARY_ENABLES_ADDR = 7'h1d;
	// reset values
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] ENABLES_RESET = 8'h00;
	// receiver flag bit positions
	localparam int RX_VALIDITY_BIT = 7;
	localparam int RX_CHECKSUM_BIT = 3;
	localparam int RX_BIPHASE_BIT = 1;
	// receiver flags that latch until read; the rest track their source level
	localparam logic [7:0] RX_LATCHED_BITS = 8'h0a;
	// converter fault register fields
	localparam int CONV_STARVED_BIT = 3;
	localparam int CONV_LEFT_CLIP_BIT = 2;
	localparam int CONV_RIGHT_CLIP_BIT = 1;
	localparam int CONV_CLICK_BIT = 0;
	localparam logic [7:0] CONV_ENABLE_WRITABLE = 8'h07;
	// event summary fields
	localparam int SUM_CONVERTER_BIT = 7;
	localparam int SUM_TX_COLLISION_BIT = 6;
	localparam int SUM_TX_EMPTY_BIT = 5;
	localparam int SUM_TX_BLOCK_SENT_BIT = 4;
	localparam int SUM_RX_MISMATCH_BIT = 3;
	localparam int SUM_RX_USER_BIT = 2;
	localparam int SUM_RX_STATUS_BIT = 1;
	localparam int SUM_RECEIVER_BIT = 0;
	// mismatch bit has no enable and never interrupts
	localparam logic [7:0] SUM_ENABLE_WRITABLE = 8'hf7;

	// one-cycle event pulses from transmitter and receiver logic
	typedef struct packed {
		logic tx_status_write_collision;
		logic tx_user_buffer_empty;
		logic tx_status_block_sent;
		logic rx_status_ab_mismatch;
		logic rx_user_block_new;
		logic rx_status_block_new;
		logic rx_status_changed;
	} link_events_s;

	// rate converter conditions
	typedef struct packed {
		logic starved;
		logic left_clip;
		logic right_clip;
		logic fast_mode;
	} converter_events_s;
endpackage

//--- hdl/audio_event_flag_aggregator.sv
// What this block does
// - receiver enable bit gates matching flag interrupt
// - converter flags: starved3, left2, right1, click0
// - starved flag set on too few cycles
// - left clip latched until converter flags read
// - right clip latched until converter flags read
// - click tracks fast mode, interrupts on change
// - converter enables bits 2..0, rest reserved
// - summary bit order converter down to receiver
// - converter summary held until summary read
// - collision bit set on write during copy
// - buffer empty bit held until summary read
// - block sent bit held until summary read
// - mismatch bit held, never interrupts
// - user block bit held until summary read
// - status block bit per change mode
// - receiver summary held until summary read
// - checksum and line faults latch until read
// - tracking receiver flags interrupt only on change
// - summary enable bit gates each summary bit except mismatch, which has none
`timescale 1ns/1ps
`default_nettype none
module audio_event_flag_aggregator (
	// clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RST,
	// register access from the control serial port front end
	input wire logic [6:0] I_REG_ADDR,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_WDATA,
	output logic [7:0] O_REG_RDATA,
	// event sources
	input wire logic [7:0] I_RX_CONDITIONS,
	input wire audio_event_pkg::converter_events_s I_CONVERTER,
	input wire audio_event_pkg::link_events_s I_LINK,
	input wire logic I_RX_BUFFER_CHANGE_MODE,
	// interrupt to host
	output logic O_IRQ
);
	logic [7:0] rx_flags; // receiver flag register contents
	logic [7:0] rx_pending; // receiver flags owed an interrupt
	logic [7:0] rx_enables; // receiver fault enables
	logic [3:0] conv_flags; // converter fault flags
	logic click_pending; // click warning changed since last read
	logic [2:0] conv_enables; // converter fault enables
	logic [7:0] summary; // event summary register
	logic [7:0] summary_enables; // event summary enables
	logic rd_rx, rd_conv, rd_sum; // read strobes per register
	logic rx_irq; // any enabled receiver flag pending
	logic conv_irq; // any enabled converter flag pending
	logic [7:0] next_summary;

	assign rd_rx = I_REG_RD && I_REG_ADDR == audio_event_pkg::RX_FAULT_FLAGS_ADDR;
	assign rd_conv = I_REG_RD && I_REG_ADDR == audio_event_pkg::CONVERTER_FAULT_FLAGS_ADDR;
	assign rd_sum = I_REG_RD && I_REG_ADDR == audio_event_pkg::EVENT_SUMMARY_ADDR;

	// receiver flags, one slice per bit
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_rx
			if (audio_event_pkg::RX_LATCHED_BITS[g]) begin : g_latched
				// latch on error pulse; a new error beats the clearing read
				always_ff @(posedge I_REF_CLK) begin
					if (I_RST) begin
						rx_flags[g] <= 1'b0;
					end else if (I_RX_CONDITIONS[g]) begin
						rx_flags[g] <= 1'b1;
					end else if (rd_rx) begin
						rx_flags[g] <= 1'b0;
					end
				end
				assign rx_pending[g] = rx_flags[g];
			end else begin : g_tracked
				logic pend;
				// level follows source; only a change owes a new interrupt
				always_ff @(posedge I_REF_CLK) begin
					if (I_RST) begin
						rx_flags[g] <= 1'b0;
						pend <= 1'b0;
					end else begin
						rx_flags[g] <= I_RX_CONDITIONS[g];
						if (I_RX_CONDITIONS[g] != rx_flags[g]) begin
							pend <= 1'b1;
						end else if (rd_rx) begin
							pend <= 1'b0;
						end
					end
				end
				assign rx_pending[g] = pend;
			end
		end
	endgenerate

	// receiver interrupt request
	assign rx_irq = |(rx_pending & rx_enables);

	// converter flags: starved and clips latch, click tracks fast mode
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			conv_flags <= 4'h0;
			click_pending <= 1'b0;
		end else begin
			conv_flags[audio_event_pkg::CONV_STARVED_BIT] <= I_CONVERTER.starved ||
				(conv_flags[audio_event_pkg::CONV_STARVED_BIT] && !rd_conv);
			conv_flags[audio_event_pkg::CONV_LEFT_CLIP_BIT] <= I_CONVERTER.left_clip ||
				(conv_flags[audio_event_pkg::CONV_LEFT_CLIP_BIT] && !rd_conv);
			conv_flags[audio_event_pkg::CONV_RIGHT_CLIP_BIT] <= I_CONVERTER.right_clip ||
				(conv_flags[audio_event_pkg::CONV_RIGHT_CLIP_BIT] && !rd_conv);
			conv_flags[audio_event_pkg::CONV_CLICK_BIT] <= I_CONVERTER.fast_mode;
			// change wins over the clearing read
			if (I_CONVERTER.fast_mode != conv_flags[audio_event_pkg::CONV_CLICK_BIT]) begin
				click_pending <= 1'b1;
			end else if (rd_conv) begin
				click_pending <= 1'b0;
			end
		end
	end

	// starved has no enable, so it is readable but never interrupts
	assign conv_irq = (conv_flags[audio_event_pkg::CONV_LEFT_CLIP_BIT] && conv_enables[2]) ||
		(conv_flags[audio_event_pkg::CONV_RIGHT_CLIP_BIT] && conv_enables[1]) ||
		(click_pending && conv_enables[0]);

	// summary next value: events set, a read of the summary clears, set wins
	always_comb begin
		next_summary = rd_sum ? 8'h00 : summary;
		if (conv_irq) next_summary[audio_event_pkg::SUM_CONVERTER_BIT] = 1'b1;
		if (I_LINK.tx_status_write_collision) begin
			next_summary[audio_event_pkg::SUM_TX_COLLISION_BIT] = 1'b1;
		end
		if (I_LINK.tx_user_buffer_empty) begin
			next_summary[audio_event_pkg::SUM_TX_EMPTY_BIT] = 1'b1;
		end
		if (I_LINK.tx_status_block_sent) begin
			next_summary[audio_event_pkg::SUM_TX_BLOCK_SENT_BIT] = 1'b1;
		end
		if (I_LINK.rx_status_ab_mismatch) begin
			next_summary[audio_event_pkg::SUM_RX_MISMATCH_BIT] = 1'b1;
		end
		if (I_LINK.rx_user_block_new) begin
			next_summary[audio_event_pkg::SUM_RX_USER_BIT] = 1'b1;
		end
		// mode picks which receiver status event counts
		if (I_RX_BUFFER_CHANGE_MODE ? I_LINK.rx_status_changed : I_LINK.rx_status_block_new) begin
			next_summary[audio_event_pkg::SUM_RX_STATUS_BIT] = 1'b1;
		end
		if (rx_irq) next_summary[audio_event_pkg::SUM_RECEIVER_BIT] = 1'b1;
	end

	// summary register
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			summary <= audio_event_pkg::FLAGS_RESET;
		end else begin
			summary <= next_summary;
		end
	end

	// writable enables; writes to read-only or unmapped addresses are ignored
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			rx_enables <= audio_event_pkg::ENABLES_RESET;
			conv_enables <= 3'h0;
			summary_enables <= audio_event_pkg::ENABLES_RESET;
		end else if (I_REG_WR) begin
			if (I_REG_ADDR == audio_event_pkg::RX_FAULT_ENABLES_ADDR) begin
				rx_enables <= I_REG_WDATA;
			end
			if (I_REG_ADDR == audio_event_pkg::CONVERTER_FAULT_ENABLES_ADDR) begin
				conv_enables <= I_REG_WDATA[2:0];
			end
			if (I_REG_ADDR == audio_event_pkg::EVENT_SUMMARY_ENABLES_ADDR) begin
				summary_enables <= I_REG_WDATA & audio_event_pkg::SUM_ENABLE_WRITABLE;
			end
		end
	end

	// read data, registered one cycle after the read strobe; reserved reads zero
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			O_REG_RDATA <= 8'h00;
		end else if (I_REG_RD) begin
			unique case (I_REG_ADDR)
				audio_event_pkg::RX_FAULT_FLAGS_ADDR: O_REG_RDATA <= rx_flags;
				audio_event_pkg::RX_FAULT_ENABLES_ADDR: O_REG_RDATA <= rx_enables;
				audio_event_pkg::CONVERTER_FAULT_FLAGS_ADDR: begin
					O_REG_RDATA <= {4'h0, conv_flags};
				end
				audio_event_pkg::CONVERTER_FAULT_ENABLES_ADDR: begin
					O_REG_RDATA <= {5'h00, conv_enables};
				end
				audio_event_pkg::EVENT_SUMMARY_ADDR: O_REG_RDATA <= summary;
				audio_event_pkg::EVENT_SUMMARY_ENABLES_ADDR: O_REG_RDATA <= summary_enables;
				default: O_REG_RDATA <= 8'h00; // unmapped
			endcase
		end
	end

	// interrupt, one cycle behind the summary so it comes from a flop
	always_ff @(posedge I_REF_CLK) begin
		if (I_RST) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(summary & summary_enables);
		end
	end

	// checks
	sequence s_sum_read;
		rd_sum;
	endsequence
	sequence s_quiet_cycle;
		!I_LINK.tx_user_buffer_empty;
	endsequence

	a_irq_raised: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(summary & summary_enables) != 8'h00 |=> O_IRQ)
		else $error("enabled summary bit did not raise interrupt");
	a_irq_quiet: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		(summary & summary_enables) == 8'h00 |=> !O_IRQ)
		else $error("interrupt raised with no enabled summary bit");
	// mismatch alone must stay silent whatever the host wrote to the enables
	a_mismatch_silent: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		summary == 8'h08 |=> !O_IRQ)
		else $error("mismatch bit raised interrupt");
	a_empty_holds: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		summary[5] && !rd_sum |=> summary[5])
		else $error("buffer empty bit dropped without read");
	a_empty_clears: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		s_sum_read ##0 s_quiet_cycle |=> !summary[5])
		else $error("buffer empty bit survived read");
	a_collision_sets: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		I_LINK.tx_status_write_collision |=> summary[6])
		else $error("collision event lost");
	a_block_sent_sets: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		I_LINK.tx_status_block_sent |=> summary[4])
		else $error("block sent event lost");
	a_user_block_sets: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		I_LINK.rx_user_block_new |=> summary[2])
		else $error("user block event lost");
	a_status_mode: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		I_RX_BUFFER_CHANGE_MODE && I_LINK.rx_status_block_new && !I_LINK.rx_status_changed
		&& !summary[1] |=> !summary[1])
		else $error("status block bit set in change mode");
	a_left_clip_holds: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		I_CONVERTER.left_clip |=> conv_flags[2] ##1 (conv_flags[2] || $past(rd_conv)))
		else $error("left clip not held until read");
	a_right_clip_sets: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		I_CONVERTER.right_clip |=> conv_flags[1])
		else $error("right clip event lost");
	a_converter_summary: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		conv_irq |=> summary[7] ##1 (summary[7] || $past(rd_sum)))
		else $error("converter summary not raised");
	a_receiver_summary: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		rx_irq |=> summary[0])
		else $error("receiver summary not raised");
	a_rx_enable_gate: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		rx_enables == 8'h00 |-> !rx_irq)
		else $error("disabled receiver flag interrupted");
	a_click_change: assert property (@(posedge I_REF_CLK) disable iff (I_RST)
		$changed(conv_flags[0]) |-> click_pending)
		else $error("click change not pending");
endmodule
`default_nettype wire

//--- dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host processor on the register port: one strobe cycle per access
module host_model (
	// clock
	input wire logic i_clk,
	// register port
	input wire logic [7:0] i_rdata,
	output logic [6:0] o_addr,
	output logic o_wr,
	output logic o_rd,
	output logic [7:0] o_wdata
);
	// idle port before the first access
	initial begin
		o_addr = 7'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_wdata = 8'h00;
	end

	// one access; the caller reads flag registers promptly after a summary bit
	task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= w;
		o_rd <= !w;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_rd <= 1'b0;
		// released lines flip so a stale value is never mistaken for a held one
		o_addr <= ~a;
		o_wdata <= ~d;
		// read data is registered on the strobe edge and stands until the next read
		@(posedge i_clk);
		q = i_rdata;
	endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk;
	logic rst;
	logic [7:0] rdata;
	logic [6:0] addr;
	logic wr;
	logic rd;
	logic [7:0] wdata;
	logic [7:0] rx_c;
	audio_event_pkg::converter_events_s conv;
	audio_event_pkg::link_events_s link;
	logic mode;
	logic irq;
	logic [7:0] rxl; // receiver levels held between pulses
	logic fm; // converter fast mode level
	int num_errors;
	int tests_run;
	int cycles;
	localparam logic [6:0] a_rx = audio_event_pkg::RX_FAULT_FLAGS_ADDR;
	localparam logic [6:0] a_rxe = audio_event_pkg::RX_FAULT_ENABLES_ADDR;
	localparam logic [6:0] a_cf = audio_event_pkg::CONVERTER_FAULT_FLAGS_ADDR;
	localparam logic [6:0] a_cfe = audio_event_pkg::CONVERTER_FAULT_ENABLES_ADDR;
	localparam logic [6:0] a_sum = audio_event_pkg::EVENT_SUMMARY_ADDR;
	localparam logic [6:0] a_sume = audio_event_pkg::EVENT_SUMMARY_ENABLES_ADDR;

	audio_event_flag_aggregator uut (.I_REF_CLK(clk), .I_RST(rst), .I_REG_ADDR(addr),
		.I_REG_WR(wr), .I_REG_RD(rd), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata),
		.I_RX_CONDITIONS(rx_c), .I_CONVERTER(conv), .I_LINK(link),
		.I_RX_BUFFER_CHANGE_MODE(mode), .O_IRQ(irq));
	host_model host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
		.o_wdata(wdata));

	// 50 MHz reference clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// hang guard: the whole sequence needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", n, e, g);
			num_errors++;
		end
	endtask

	// read a register and compare
	task automatic rc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		host.access(1'b0, a, 8'h00, q);
		chk($sformatf("reg %h", a), e, q);
	endtask

	task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.access(1'b1, a, d, q);
	endtask

	// one-cycle event pulses on top of the held levels, then let the chain settle
	task automatic ev(input logic [7:0] r, input logic [2:0] c, input logic [6:0] l);
		@(posedge clk);
		rx_c <= rxl | r;
		conv <= {c, fm};
		link <= l;
		@(posedge clk);
		rx_c <= rxl;
		conv <= {3'h0, fm};
		link <= 7'h00;
		repeat (4) @(posedge clk);
	endtask

	initial begin
		rst = 1'b1;
		mode = 1'b0;
		rx_c = 8'h00;
		conv = 4'h0;
		link = 7'h00;
		rxl = 8'h00;
		fm = 1'b0;
		num_errors = 0;
		tests_run = 0;
		cycles = 0;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rc(a_cf, 8'h00);
		rc(a_sum, 8'h00);
		wr_reg(a_cfe, 8'hff);
		rc(a_cfe, 8'h07);
		wr_reg(a_sume, 8'hff);
		rc(a_sume, 8'hf7);
		wr_reg(a_rxe, 8'hff);
		rc(a_rxe, 8'hff);
		// each link event from collision down to user block lands in its own summary bit; mismatch stays silent
		for (int k = 6; k >= 2; k--) begin
			ev(8'h00, 3'h0, 7'(1 << k));
			chk("irq", {7'h00, k != 3}, {7'h00, irq});
			rc(a_sum, 8'(1 << k));
			rc(a_sum, 8'h00);
		end
		// status block bit: new block counts in mode 0, a change in mode 1
		for (int m = 0; m < 2; m++) begin
			for (int k = 0; k < 2; k++) begin
				mode <= m[0];
				ev(8'h00, 3'h0, 7'(1 << k));
				rc(a_sum, ((k == 1) ^ (m == 1)) ? 8'h02 : 8'h00);
			end
		end
		// starved, left and right flags latch until the flags register is read
		for (int j = 2; j >= 0; j--) begin
			ev(8'h00, 3'(1 << j), 7'h00);
			rc(a_cf, 8'(2 << j));
			rc(a_cf, 8'h00);
			rc(a_sum, (j < 2) ? 8'h80 : 8'h00);
		end
		// click warning tracks fast mode and interrupts only on a change
		fm <= 1'b1;
		ev(8'h00, 3'h0, 7'h00);
		rc(a_cf, 8'h01);
		rc(a_cf, 8'h01);
		rc(a_sum, 8'h80);
		rc(a_sum, 8'h00);
		fm <= 1'b0;
		ev(8'h00, 3'h0, 7'h00);
		rc(a_cf, 8'h00);
		rc(a_sum, 8'h80);
		// latched receiver fault, enabled then masked
		ev(8'h0a, 3'h0, 7'h00);
		chk("irq", 8'h01, {7'h00, irq});
		rc(a_rx, 8'h0a);
		rc(a_rx, 8'h00);
		rc(a_sum, 8'h01);
		rc(a_sum, 8'h00);
		wr_reg(a_rxe, 8'hf5);
		ev(8'h0a, 3'h0, 7'h00);
		rc(a_sum, 8'h00);
		rc(a_rx, 8'h0a);
		// tracking receiver flag keeps its level after a read
		rxl <= 8'h01;
		ev(8'h00, 3'h0, 7'h00);
		rc(a_rx, 8'h01);
		rc(a_rx, 8'h01);
		rc(a_sum, 8'h01);
		rc(a_sum, 8'h00);
		// a mid-run reset drops pending events and enables
		rxl <= 8'h00;
		ev(8'h00, 3'h0, 7'h20);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rc(a_sum, 8'h00);
		rc(a_sume, 8'h00);
		chk("irq", 8'h00, {7'h00, irq});
		conclude();
	end
endmodule
`default_nettype wire
